// ---- moc_pkg.sv ----
// Constants and types shared by the main oscillator control block
package moc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_MAIN_OSC = 8'h00;
  localparam logic [7:0] OFS_MAIN_FREQ = 8'h04;
  localparam logic [7:0] OFS_POWER_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // main_osc_reg fields
  localparam int unsigned BIT_OSC_EN = 0;
  localparam int unsigned BIT_BYPASS = 1;
  localparam int unsigned BIT_MAIN_SEL = 2;
  localparam int unsigned STARTUP_LSB = 8;
  localparam int unsigned STARTUP_W = 8;
  // main_freq_reg fields
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned BIT_FREQ_RDY = 16;
  // power_status_reg fields
  localparam int unsigned BIT_ST_STABLE = 0;
  localparam int unsigned BIT_ST_FREQ_RDY = 1;
  localparam int unsigned BIT_ST_MAIN_SEL = 2;
  // Interrupt status, clear and mask layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_STABLE = 0;
  localparam int unsigned IRQ_FREQ_RDY = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [STARTUP_W-1:0] STARTUP_RESET = 8'h00;
  // Slow clock division for the startup counter
  localparam int unsigned SLOW_DIV = 8;
  localparam int unsigned PRESC_W = 3;
  // Slow clock falling edges that close a frequency measurement
  localparam int unsigned FREQ_FALLS = 16;
  localparam int unsigned FALL_W = 5;
  typedef enum logic [3:0] {
    MOC_IDLE = 4'b0001,
    MOC_WAIT = 4'b0010,
    MOC_COUNT = 4'b0100,
    MOC_DONE = 4'b1000
  } moc_freq_state_t;
endpackage

// ---- moc_edge_if.sv ----
// Synchronised edge pulses of one external clock pin
`timescale 1ns/1ps
interface moc_edge_if;
  logic rise;
  logic fall;
  modport src(output rise, output fall);
  modport dst(input rise, input fall);
endinterface

// ---- moc_edge_sync.sv ----
// Two-stage synchroniser with edge detection for a pin-driven clock
`timescale 1ns/1ps
module moc_edge_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinIn,
  moc_edge_if.src edge_o
);
  logic meta;
  logic sync;
  logic syncQ;

  // First stage feeds only the second one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      syncQ <= 1'b0;
    end else begin
      meta <= pinIn;
      sync <= meta;
      syncQ <= sync;
    end
  end

  assign edge_o.rise = sync & ~syncQ;
  assign edge_o.fall = ~sync & syncQ;
endmodule

// ---- moc_main_osc_ctrl.sv ----
// Main oscillator enable, startup timer and main clock frequency counter
`timescale 1ns/1ps
// Functional notes
// - Reset: oscillator off, slow clock selected
// - Clearing enable stops oscillator, clears stable
// - Enable write clears stable, loads down-counter
// - Startup count is eight bits wide
// - Counter at zero sets stable flag
// - Stable rise interrupts when mask bit set
// - Counting starts at next slow rising edge
// - Sixteenth slow falling edge stops, sets ready
// - Final count readable as main cycles
// - Slow clock is the permanent timing reference
module moc_main_osc_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slowClk,
  input wire logic mainClk,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [moc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [moc_pkg::DATA_W-1:0] wb_dat_i,
  output logic [moc_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mainOscEnable,
  output logic oscBypassSelect,
  output logic mainClkSelect,
  output logic irq
);
  import moc_pkg::*;

  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(SLOW_DIV - 1);
  localparam logic [FALL_W-1:0] FALL_LAST = FALL_W'(FREQ_FALLS - 1);
  localparam logic [FREQ_W-1:0] FREQ_MAX = {FREQ_W{1'b1}};

  moc_edge_if slowEdge ();
  moc_edge_if mainEdge ();

  moc_edge_sync u_slow_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(slowClk),
    .edge_o(slowEdge)
  );

  // Main clock is edge-sampled, so it must stay below clk/2 to be counted
  moc_edge_sync u_main_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(mainClk),
    .edge_o(mainEdge)
  );

  logic wbReq;
  logic ctrlWr;
  logic enStart;
  logic enStop;
  logic clrWr;
  logic maskWr;
  logic [STARTUP_W-1:0] startupCount;
  logic [STARTUP_W-1:0] loadCount;
  logic mainOscStable;
  logic starting;
  logic [STARTUP_W-1:0] startCnt;
  logic [PRESC_W-1:0] presc;
  moc_freq_state_t freqState;
  logic [FREQ_W-1:0] mainFreqCount;
  logic [FALL_W-1:0] fallCnt;
  logic freqCountReady;
  logic stableQ;
  logic readyQ;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] irqEvent;
  logic [DATA_W-1:0] rdData;

  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ctrlWr = wbReq & wb_we_i & (wb_adr_i == OFS_MAIN_OSC);
  assign clrWr = wbReq & wb_we_i & (wb_adr_i == OFS_IRQ_CLEAR) & wb_sel_i[0];
  assign maskWr = wbReq & wb_we_i & (wb_adr_i == OFS_IRQ_MASK) & wb_sel_i[0];
  assign enStart = ctrlWr & wb_sel_i[0] & wb_dat_i[BIT_OSC_EN];
  assign enStop = ctrlWr & wb_sel_i[0] & ~wb_dat_i[BIT_OSC_EN];
  // A write without the count lane reuses the stored count
  assign loadCount = wb_sel_i[1] ? wb_dat_i[STARTUP_LSB +: STARTUP_W] : startupCount;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mainOscEnable <= 1'b0;
      oscBypassSelect <= 1'b0;
      mainClkSelect <= 1'b0;
      startupCount <= STARTUP_RESET;
    end else if (ctrlWr) begin
      if (wb_sel_i[0]) begin
        mainOscEnable <= wb_dat_i[BIT_OSC_EN];
        oscBypassSelect <= wb_dat_i[BIT_BYPASS];
        mainClkSelect <= wb_dat_i[BIT_MAIN_SEL];
      end
      if (wb_sel_i[1]) begin
        startupCount <= wb_dat_i[STARTUP_LSB +: STARTUP_W];
      end
    end
  end

  // Startup timer; any enabling write restarts it from loadCount, the written count or the stored one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mainOscStable <= 1'b0;
      starting <= 1'b0;
      startCnt <= STARTUP_RESET;
      presc <= '0;
    end else if (enStop) begin
      mainOscStable <= 1'b0;
      starting <= 1'b0;
    end else if (enStart) begin
      mainOscStable <= 1'b0;
      starting <= 1'b1;
      startCnt <= loadCount;
      presc <= '0;
    end else if (starting) begin
      if (startCnt == '0) begin
        mainOscStable <= 1'b1;
        starting <= 1'b0;
      end else if (slowEdge.rise) begin
        presc <= presc + 1'b1;
        if (presc == PRESC_LAST) begin
          startCnt <= startCnt - 1'b1;
        end
      end
    end
  end

  // Frequency measurement; loss of stable or enable aborts it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freqState <= MOC_IDLE;
      mainFreqCount <= '0;
      fallCnt <= '0;
      freqCountReady <= 1'b0;
    end else if (!mainOscEnable || !mainOscStable) begin
      freqState <= MOC_IDLE;
      freqCountReady <= 1'b0;
    end else begin
      case (freqState)
        MOC_IDLE: begin
          freqState <= MOC_WAIT;
        end
        MOC_WAIT: begin
          if (slowEdge.rise) begin
            freqState <= MOC_COUNT;
            mainFreqCount <= '0;
            fallCnt <= '0;
          end
        end
        MOC_COUNT: begin
          if (mainEdge.rise && mainFreqCount != FREQ_MAX) begin
            mainFreqCount <= mainFreqCount + 1'b1;
          end
          if (slowEdge.fall) begin
            if (fallCnt == FALL_LAST) begin
              freqState <= MOC_DONE;
              freqCountReady <= 1'b1;
            end else begin
              fallCnt <= fallCnt + 1'b1;
            end
          end
        end
        MOC_DONE: begin
          freqState <= MOC_DONE;
        end
        default: begin
          freqState <= MOC_IDLE;
        end
      endcase
    end
  end

  assign irqEvent[IRQ_STABLE] = mainOscStable & ~stableQ;
  assign irqEvent[IRQ_FREQ_RDY] = freqCountReady & ~readyQ;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stableQ <= 1'b0;
      readyQ <= 1'b0;
      irqStatus <= '0;
    end else begin
      stableQ <= mainOscStable;
      readyQ <= freqCountReady;
      irqStatus <= (irqStatus & ~(clrWr ? wb_dat_i[IRQ_W-1:0] : '0)) | irqEvent;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask <= IRQ_MASK_RESET;
    end else if (maskWr) begin
      irqMask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  always_comb begin
    rdData = '0;
    if (wb_adr_i == OFS_MAIN_OSC) begin
      rdData[BIT_OSC_EN] = mainOscEnable;
      rdData[BIT_BYPASS] = oscBypassSelect;
      rdData[BIT_MAIN_SEL] = mainClkSelect;
      rdData[STARTUP_LSB +: STARTUP_W] = startupCount;
    end else if (wb_adr_i == OFS_MAIN_FREQ) begin
      rdData[FREQ_W-1:0] = mainFreqCount;
      rdData[BIT_FREQ_RDY] = freqCountReady;
    end else if (wb_adr_i == OFS_POWER_STATUS) begin
      rdData[BIT_ST_STABLE] = mainOscStable;
      rdData[BIT_ST_FREQ_RDY] = freqCountReady;
      rdData[BIT_ST_MAIN_SEL] = mainClkSelect;
    end else if (wb_adr_i == OFS_IRQ_STATUS) begin
      rdData[IRQ_W-1:0] = irqStatus;
    end else if (wb_adr_i == OFS_IRQ_MASK) begin
      rdData[IRQ_W-1:0] = irqMask;
    end
  end

  // Single-cycle acknowledge; unmapped addresses read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        wb_dat_o <= rdData;
      end
    end
  end

  a_reset_off: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !mainOscEnable && !mainClkSelect && !mainOscStable)
    else $error("oscillator not off after reset");

  a_disable_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    enStop |=> !mainOscStable && !mainOscEnable)
    else $error("stable flag survived disable");

  a_enable_loads: assert property (
    @(posedge clk) disable iff (!reset_n)
    enStart && wb_sel_i[1] |=> !mainOscStable && starting && startCnt == $past(wb_dat_i[15:8]))
    else $error("startup count not loaded");

  a_zero_stable: assert property (
    @(posedge clk) disable iff (!reset_n)
    starting && startCnt == '0 && !ctrlWr |=> mainOscStable && !starting)
    else $error("stable not set at zero");

  a_irq_raise: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(mainOscStable) && irqMask[IRQ_STABLE] && !maskWr |=> irq)
    else $error("stable interrupt missing");

  a_count_start: assert property (
    @(posedge clk) disable iff (!reset_n)
    freqState == MOC_WAIT && slowEdge.rise && mainOscEnable && mainOscStable
      |=> freqState == MOC_COUNT && mainFreqCount == '0)
    else $error("count did not start on slow rise");

  a_ready_sixteen: assert property (
    @(posedge clk) disable iff (!reset_n)
    freqState == MOC_COUNT && slowEdge.fall && fallCnt == 5'd15 && mainOscEnable && mainOscStable
      |=> freqCountReady && freqState == MOC_DONE)
    else $error("ready not set at sixteenth fall");

  a_count_frozen: assert property (
    @(posedge clk) disable iff (!reset_n)
    freqState == MOC_DONE ##1 freqState == MOC_DONE |-> $stable(mainFreqCount))
    else $error("count moved after ready");

  a_ready_drop: assert property (
    @(posedge clk) disable iff (!reset_n)
    !mainOscEnable |=> !freqCountReady)
    else $error("ready held while disabled");
endmodule

// ---- moc_osc_model.sv ----
// Behavioural crystal or external clock feeding the main oscillator pin
`timescale 1ns/1ps
module moc_osc_model (
  input wire logic enable,
  input wire logic bypass,
  output logic mainClk
);
  // Period of 700 ns keeps the pin below half the system clock rate
  localparam int HALF_NS = 350;
  initial begin
    mainClk = 1'b0;
    forever begin
      #HALF_NS;
      // A stopped crystal leaves the pin quiet, not toggling
      if (enable || bypass) begin
        mainClk = ~mainClk;
      end else begin
        mainClk = 1'b0;
      end
    end
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the main oscillator control block
`timescale 1ns/1ps
module tb;
  import moc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slowClk = 1'b0;
  logic mainClk;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [DATA_W-1:0] datI = 32'h0;
  logic [DATA_W-1:0] datO;
  logic [DATA_W-1:0] rd;
  logic ack;
  logic oscEn;
  logic bypass;
  logic mainSel;
  logic irq;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int t0;
  // Count window runs from a slow rise to the sixteenth slow fall: 15.5 slow periods
  localparam int SLOW_HALF = 1400;
  // Matches the oscillator model's full period
  localparam int MAIN_PERIOD = 700;
  localparam int FREQ_EXP = (2 * int'(FREQ_FALLS) - 1) * SLOW_HALF / MAIN_PERIOD;

  moc_main_osc_ctrl uut (.clk(clk), .reset_n(reset_n), .slowClk(slowClk), .mainClk(mainClk),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .mainOscEnable(oscEn), .oscBypassSelect(bypass),
    .mainClkSelect(mainSel), .irq(irq));
  moc_osc_model osc (.enable(oscEn), .bypass(bypass), .mainClk(mainClk));

  initial forever #50 clk = ~clk;
  initial forever #SLOW_HALF slowClk = ~slowClk;

  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  // One main edge of slack for the pin synchronisers
  function automatic logic freq_ok(input logic [15:0] cnt);
    return (cnt >= 16'(FREQ_EXP - 1)) && (cnt <= 16'(FREQ_EXP + 1));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle: hold request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    datI <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic poll(input logic [7:0] a, input int bitn);
    repeat (300) begin
      wb(1'b0, a, 32'h0);
      if (rd[bitn] === 1'b1) return;
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, OFS_MAIN_OSC, 32'h0);
    chk(rd, 32'h0, "osc reg after reset");
    chk({30'h0, oscEn, mainSel}, 32'h0, "outputs after reset");
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    wb(1'b1, OFS_IRQ_MASK, 32'h1);
    wb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h1, "mask readback");
    // Count of two ticks outlasts the model's start time
    wb(1'b1, OFS_MAIN_OSC, 32'h0201);
    t0 = cycles;
    chk({31'h0, oscEn}, 32'h1, "enable output");
    wb(1'b0, OFS_POWER_STATUS, 32'h0);
    chk({31'h0, rd[BIT_ST_STABLE]}, 32'h0, "stable during startup");
    chk({31'h0, irq}, 32'h0, "no irq during startup");
    poll(OFS_POWER_STATUS, BIT_ST_STABLE);
    chk({31'h0, (cycles - t0 >= 420) && (cycles - t0 <= 500)}, 32'h1, "startup time");
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq on stable");
    wb(1'b1, OFS_IRQ_CLEAR, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    poll(OFS_MAIN_FREQ, BIT_FREQ_RDY);
    chk({31'h0, freq_ok(rd[15:0])}, 32'h1, "freq count");
    wb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2, "sticky ready event");
    chk({31'h0, irq}, 32'h0, "masked event");
    wb(1'b1, OFS_MAIN_OSC, 32'h0);
    wb(1'b0, OFS_POWER_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0, "stop clears flags");
    chk({31'h0, oscEn}, 32'h0, "enable dropped");
    wb(1'b1, OFS_MAIN_OSC, 32'h0001);
    wb(1'b0, OFS_MAIN_FREQ, 32'h0);
    chk({31'h0, rd[BIT_FREQ_RDY]}, 32'h0, "ready restarts");
    poll(OFS_MAIN_FREQ, BIT_FREQ_RDY);
    chk({31'h0, freq_ok(rd[15:0])}, 32'h1, "remeasured count");
    // External clock: bypass on, enable off, main clock chosen, full count field
    wb(1'b1, OFS_MAIN_OSC, 32'h0000ff06);
    chk({29'h0, mainSel, bypass, oscEn}, 32'h6, "bypass outputs");
    wb(1'b0, OFS_MAIN_OSC, 32'h0);
    chk(rd, 32'h0000ff06, "count readback");
    wb(1'b0, OFS_POWER_STATUS, 32'h0);
    chk(rd, 32'h4, "main select status");
    print_verdict();
  end
endmodule
